// file: core/dma_desc_pkg.sv
package dma_desc_pkg;
    localparam int NCH = 5;
    localparam int CW = 13;
    localparam int NTRIG = 30;
    localparam int DESC_BYTES = 8;
    localparam logic [2:0] LAST_BYTE = 3'h7;
    // descriptor byte offsets and field bits
    localparam int B_SRC_HI = 0;
    localparam int B_SRC_LO = 1;
    localparam int B_DST_HI = 2;
    localparam int B_DST_LO = 3;
    localparam int B_VARIABLE_COUNT_SELECT = 4;
    localparam int B_LEN_LO = 5;
    localparam int B_MODE = 6;
    localparam int B_STEP = 7;
    localparam int VSEL_MSB = 7;
    localparam int VSEL_LSB = 5;
    localparam int LENH_MSB = 4;
    localparam int WORD_BIT = 7;
    localparam int KIND_MSB = 6;
    localparam int KIND_LSB = 5;
    localparam int TRIGGER_SELECT_MSB = 4;
    localparam int SSTEP_MSB = 7;
    localparam int SSTEP_LSB = 6;
    localparam int TSTEP_MSB = 5;
    localparam int TSTEP_LSB = 4;
    localparam int IE_BIT = 3;
    localparam int M8_BIT = 2;
    localparam int PRIO_MSB = 1;
    localparam int WLEN_MSB = 12;
    localparam int BLEN7_MSB = 6;
    // variable count codes
    localparam logic [2:0] VSEL_P1 = 3'h1;
    localparam logic [2:0] VSEL_P0 = 3'h2;
    localparam logic [2:0] VSEL_P2 = 3'h3;
    localparam logic [2:0] VSEL_P3 = 3'h4;
    localparam logic [13:0] ADD_ONE = 14'h0001;
    localparam logic [13:0] ADD_TWO = 14'h0002;
    localparam logic [13:0] ADD_THREE = 14'h0003;
    localparam logic [4:0] TRIGGER_SELECT_NONE = 5'h00;
    localparam logic [4:0] TRIGGER_SELECT_PREV = 5'h01;
    localparam logic [4:0] TRIGGER_SELECT_BASE = 5'h02;
    // register port offsets and bits
    localparam logic [2:0] R_ARM = 3'h0;
    localparam logic [2:0] R_REQ = 3'h1;
    localparam logic [2:0] R_FLAG = 3'h2;
    localparam logic [2:0] R_P0H = 3'h3;
    localparam logic [2:0] R_P0L = 3'h4;
    localparam logic [2:0] R_P1H = 3'h5;
    localparam logic [2:0] R_P1L = 3'h6;
    localparam int ABORT_BIT = 7;
    typedef enum logic [1:0] {K_SINGLE = 2'h0, K_BLOCK = 2'h1, K_RSINGLE = 2'h2, K_RBLOCK = 2'h3} kind_t;
    typedef enum logic [1:0] {S_ZERO = 2'h0, S_ONE = 2'h1, S_TWO = 2'h2, S_NEG = 2'h3} step_t;
    typedef enum logic [1:0] {P_LOW = 2'h0, P_GUAR = 2'h1, P_HIGH = 2'h2, P_TOP = 2'h3} prio_t;
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01, ST_FETCH = 7'h02, ST_FWAIT = 7'h04, ST_LOAD = 7'h08,
        ST_READ = 7'h10, ST_RWAIT = 7'h20, ST_WRITE = 7'h40
    } st_t;
    typedef struct packed {
        logic [15:0] src;
        logic [15:0] dst;
        logic [2:0] vsel;
        logic [CW-1:0] len;
        logic word;
        kind_t kind;
        logic [4:0] trigger_select;
        step_t sstep;
        step_t tstep;
        logic ie;
        logic m8;
        prio_t prio;
    } desc_t;
    typedef struct packed {
        logic [15:0] addr;
        logic rd;
        logic wr;
        logic word;
        logic [15:0] wdata;
    } mem_req_t;
endpackage : dma_desc_pkg

// file: core/dma_desc_decode.sv
`timescale 1ns/1ps
module dma_desc_decode import dma_desc_pkg::*; (
    input wire logic [7:0][7:0] raw,
    output desc_t desc
);
    assign desc.src = {raw[B_SRC_HI], raw[B_SRC_LO]};
    assign desc.dst = {raw[B_DST_HI], raw[B_DST_LO]};
    assign desc.vsel = raw[B_VARIABLE_COUNT_SELECT][VSEL_MSB:VSEL_LSB];
    assign desc.len = {raw[B_VARIABLE_COUNT_SELECT][LENH_MSB:0], raw[B_LEN_LO]};
    assign desc.word = raw[B_MODE][WORD_BIT];
    assign desc.kind = kind_t'(raw[B_MODE][KIND_MSB:KIND_LSB]);
    assign desc.trigger_select = raw[B_MODE][TRIGGER_SELECT_MSB:0];
    assign desc.sstep = step_t'(raw[B_STEP][SSTEP_MSB:SSTEP_LSB]);
    assign desc.tstep = step_t'(raw[B_STEP][TSTEP_MSB:TSTEP_LSB]);
    assign desc.ie = raw[B_STEP][IE_BIT];
    assign desc.m8 = raw[B_STEP][M8_BIT];
    assign desc.prio = prio_t'(raw[B_STEP][PRIO_MSB:0]);
endmodule : dma_desc_decode

// file: core/dma_desc_engine.sv
`timescale 1ns/1ps
module dma_desc_engine import dma_desc_pkg::*; (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output mem_req_t mem_out,
    input wire logic [15:0] mem_rdata,
    input wire logic cpu_req,
    input wire logic [NTRIG-1:0] trigger_select_src,
    output logic [NCH-1:0] cpu_irq
);
    st_t st_ff;
    st_t nxt_st;
    logic [2:0] cur_ff;
    logic [2:0] idx_ff;
    logic [7:0][7:0] raw_ff;
    desc_t desc_ff [NCH];
    logic [15:0] src_ff [NCH];
    logic [15:0] dst_ff [NCH];
    logic [CW-1:0] left_ff [NCH];
    logic [NCH-1:0] first_ff;
    logic [NCH-1:0] need_ff;
    logic [NCH-1:0] arm_ff;
    logic [NCH-1:0] req_ff;
    logic [NCH-1:0] flag_ff;
    logic [NCH-1:0] irq_ff;
    logic [NCH-1:0] done_q_ff;
    logic [15:0] ptr0_ff;
    logic [15:0] ptr1_ff;
    logic [15:0] data_ff;
    logic alt_ff;
    mem_req_t mem_ff;
    logic [7:0] rdata_ff;
    desc_t dec;
    desc_t cd;
    logic [NCH-1:0] hw_trigger_select;
    logic [NCH-1:0] cur_vec;
    logic [NCH-1:0] done_vec;
    logic pick_v;
    logic pick_f;
    logic [2:0] pick_c;
    logic gnt;
    logic alive;
    logic take;
    logic rd_ev;
    logic wr_ev;
    logic done_ev;
    logic load_ev;
    logic repeat_kind;
    logic variable_count_select_on;
    logic [13:0] vn;
    logic [13:0] vtot;
    logic [CW-1:0] vcap;
    logic [15:0] fetch_addr;

    dma_desc_decode u_dec (
        .raw(raw_ff),
        .desc(dec)
    );

    function automatic logic [15:0] step_ptr(input logic [15:0] p, input step_t c, input logic w);
        logic [15:0] u;
        u = w ? 16'h0002 : 16'h0001;
        case (c)
            S_ONE: step_ptr = p + u;
            S_TWO: step_ptr = p + (u << 1);
            S_NEG: step_ptr = p - u;
            default: step_ptr = p;
        endcase
    endfunction : step_ptr

    assign cd = desc_ff[cur_ff];
    assign cur_vec = NCH'(1) << cur_ff;
    assign alive = arm_ff[cur_ff];
    assign repeat_kind = (cd.kind == K_RSINGLE) || (cd.kind == K_RBLOCK);
    // channel against cpu on each data access
    assign gnt = !cpu_req || (cd.prio == P_HIGH) || (cd.prio == P_TOP) || ((cd.prio == P_GUAR) && alt_ff);
    assign take = (st_ff == ST_IDLE) && pick_v && !pick_f;
    assign rd_ev = (st_ff == ST_READ) && alive && gnt;
    assign wr_ev = (st_ff == ST_WRITE) && alive && gnt;
    assign done_ev = wr_ev && (left_ff[cur_ff] <= CW'(1));
    assign done_vec = done_ev ? cur_vec : '0;
    assign load_ev = (st_ff == ST_LOAD);
    // channel 0 alone, channels 1-4 stride eight bytes
    assign fetch_addr = (cur_ff == 3'h0 ? ptr0_ff : ptr1_ff + 16'((cur_ff - 3'h1) * DESC_BYTES)) + 16'(idx_ff);

    // hardware trigger per channel
    for (genvar c = 0; c < NCH; c++) begin : g_trigger_select
        always_comb begin
            hw_trigger_select[c] = 1'b0;
            if (arm_ff[c] && !need_ff[c]) begin
                if (desc_ff[c].trigger_select == TRIGGER_SELECT_PREV) begin
                    hw_trigger_select[c] = done_q_ff[(c + NCH - 1) % NCH];
                end else if (desc_ff[c].trigger_select >= TRIGGER_SELECT_BASE) begin
                    hw_trigger_select[c] = trigger_select_src[5'(desc_ff[c].trigger_select - TRIGGER_SELECT_BASE)];
                end
            end
        end
    end

    // pick: fetch first, then lowest pending channel
    always_comb begin
        pick_v = 1'b0;
        pick_f = 1'b0;
        pick_c = '0;
        for (int i = NCH - 1; i >= 0; i--) begin
            if (arm_ff[i] && !need_ff[i] && req_ff[i]) begin
                pick_v = 1'b1;
                pick_c = 3'(i);
            end
        end
        for (int i = NCH - 1; i >= 0; i--) begin
            if (arm_ff[i] && need_ff[i]) begin
                pick_v = 1'b1;
                pick_f = 1'b1;
                pick_c = 3'(i);
            end
        end
    end

    // variable count from first unit
    always_comb begin
        variable_count_select_on = (cd.vsel == VSEL_P1) || (cd.vsel == VSEL_P0) || (cd.vsel == VSEL_P2) || (cd.vsel == VSEL_P3);
        if (cd.word) begin
            vn = 14'(mem_rdata[WLEN_MSB:0]);
        end else if (cd.m8) begin
            vn = 14'(mem_rdata[BLEN7_MSB:0]);
        end else begin
            vn = 14'(mem_rdata[7:0]);
        end
        case (cd.vsel)
            VSEL_P1: vtot = vn + ADD_ONE;
            VSEL_P2: vtot = vn + ADD_TWO;
            VSEL_P3: vtot = vn + ADD_THREE;
            default: vtot = vn;
        endcase
        vcap = (vtot > 14'(cd.len)) ? cd.len : vtot[CW-1:0];
    end

    always_comb begin
        nxt_st = st_ff;
        case (st_ff)
            ST_IDLE: if (pick_v) nxt_st = pick_f ? ST_FETCH : ST_READ;
            ST_FETCH: if (!alive) nxt_st = ST_IDLE; else if (!cpu_req) nxt_st = ST_FWAIT;
            ST_FWAIT: nxt_st = (idx_ff == LAST_BYTE) ? ST_LOAD : ST_FETCH;
            ST_LOAD: nxt_st = ST_IDLE;
            ST_READ: if (!alive) nxt_st = ST_IDLE; else if (gnt) nxt_st = ST_RWAIT;
            ST_RWAIT: nxt_st = ST_WRITE;
            ST_WRITE: begin
                if (!alive) begin
                    nxt_st = ST_IDLE;
                end else if (gnt) begin
                    // block kinds run the whole count
                    nxt_st = (!done_ev && cd.kind == K_BLOCK) || (!done_ev && cd.kind == K_RBLOCK) ? ST_READ : ST_IDLE;
                end
            end
            default: nxt_st = ST_IDLE;
        endcase
    end

    // sequencer
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= ST_IDLE;
            cur_ff <= '0;
            idx_ff <= '0;
            raw_ff <= '0;
            data_ff <= '0;
            alt_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            if (st_ff == ST_IDLE && pick_v) begin
                cur_ff <= pick_c;
                idx_ff <= '0;
            end
            if (st_ff == ST_FWAIT) begin
                raw_ff[idx_ff] <= mem_rdata[7:0];
                idx_ff <= idx_ff + 3'h1;
            end
            if (st_ff == ST_RWAIT) begin
                data_ff <= mem_rdata;
            end
            // guaranteed level wins on a second try
            if ((st_ff == ST_READ || st_ff == ST_WRITE) && alive) begin
                alt_ff <= !gnt;
            end
        end
    end

    // memory port
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_ff <= '0;
        end else begin
            mem_ff.rd <= 1'b0;
            mem_ff.wr <= 1'b0;
            if (st_ff == ST_FETCH && alive && !cpu_req) begin
                mem_ff.rd <= 1'b1;
                mem_ff.word <= 1'b0;
                mem_ff.addr <= fetch_addr;
            end else if (rd_ev) begin
                mem_ff.rd <= 1'b1;
                mem_ff.word <= cd.word;
                mem_ff.addr <= src_ff[cur_ff];
            end else if (wr_ev) begin
                mem_ff.wr <= 1'b1;
                mem_ff.word <= cd.word;
                mem_ff.addr <= dst_ff[cur_ff];
                mem_ff.wdata <= data_ff;
            end
        end
    end

    // per channel pointers, counts and descriptors
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NCH; i++) begin
                desc_ff[i] <= '0;
                src_ff[i] <= '0;
                dst_ff[i] <= '0;
                left_ff[i] <= '0;
            end
            first_ff <= '0;
        end else begin
            if (load_ev) begin
                desc_ff[cur_ff] <= dec;
                src_ff[cur_ff] <= dec.src;
                dst_ff[cur_ff] <= dec.dst;
                left_ff[cur_ff] <= dec.len;
                first_ff[cur_ff] <= 1'b1;
            end
            if (st_ff == ST_RWAIT && first_ff[cur_ff] && variable_count_select_on) begin
                left_ff[cur_ff] <= vcap;
            end
            if (wr_ev) begin
                first_ff[cur_ff] <= 1'b0;
                src_ff[cur_ff] <= step_ptr(src_ff[cur_ff], cd.sstep, cd.word);
                dst_ff[cur_ff] <= step_ptr(dst_ff[cur_ff], cd.tstep, cd.word);
                left_ff[cur_ff] <= left_ff[cur_ff] - CW'(1);
                if (done_ev) begin
                    left_ff[cur_ff] <= '0;
                    if (repeat_kind) begin
                        src_ff[cur_ff] <= cd.src;
                        dst_ff[cur_ff] <= cd.dst;
                        left_ff[cur_ff] <= cd.len;
                        first_ff[cur_ff] <= 1'b1;
                    end
                end
            end
        end
    end

    // arm, request and done flags
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            arm_ff <= '0;
            need_ff <= '0;
            req_ff <= '0;
            flag_ff <= '0;
        end else begin
            if (done_ev && !repeat_kind) begin
                arm_ff[cur_ff] <= 1'b0;
            end
            if (load_ev) begin
                need_ff[cur_ff] <= 1'b0;
            end
            if (reg_wr && reg_addr == R_ARM) begin
                if (reg_wdata[ABORT_BIT]) begin
                    arm_ff <= arm_ff & ~reg_wdata[NCH-1:0];
                end else begin
                    arm_ff <= reg_wdata[NCH-1:0];
                    need_ff <= (need_ff & reg_wdata[NCH-1:0]) | (reg_wdata[NCH-1:0] & ~arm_ff);
                end
            end
            // software bit or hardware source, set wins
            req_ff <= (req_ff & ~(take ? cur_vec : '0)) | hw_trigger_select
                | ((reg_wr && reg_addr == R_REQ) ? reg_wdata[NCH-1:0] : '0);
            flag_ff <= (flag_ff & ~((reg_wr && reg_addr == R_FLAG) ? reg_wdata[NCH-1:0] : '0)) | done_vec;
        end
    end

    // completion pulses
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_ff <= '0;
            done_q_ff <= '0;
        end else begin
            done_q_ff <= done_vec;
            irq_ff <= cd.ie ? done_vec : '0;
        end
    end

    // register port
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ptr0_ff <= '0;
            ptr1_ff <= '0;
            rdata_ff <= '0;
        end else begin
            if (reg_wr) begin
                if (reg_addr == R_P0H) begin
                    ptr0_ff[15:8] <= reg_wdata;
                end else if (reg_addr == R_P0L) begin
                    ptr0_ff[7:0] <= reg_wdata;
                end else if (reg_addr == R_P1H) begin
                    ptr1_ff[15:8] <= reg_wdata;
                end else if (reg_addr == R_P1L) begin
                    ptr1_ff[7:0] <= reg_wdata;
                end
            end
            rdata_ff <= '0;
            if (reg_rd) begin
                if (reg_addr == R_ARM) begin
                    rdata_ff <= 8'(arm_ff);
                end else if (reg_addr == R_REQ) begin
                    rdata_ff <= 8'(req_ff);
                end else if (reg_addr == R_FLAG) begin
                    rdata_ff <= 8'(flag_ff);
                end else if (reg_addr == R_P0H) begin
                    rdata_ff <= ptr0_ff[15:8];
                end else if (reg_addr == R_P0L) begin
                    rdata_ff <= ptr0_ff[7:0];
                end else if (reg_addr == R_P1H) begin
                    rdata_ff <= ptr1_ff[15:8];
                end else if (reg_addr == R_P1L) begin
                    rdata_ff <= ptr1_ff[7:0];
                end
            end
        end
    end

    assign reg_rdata = rdata_ff;
    assign mem_out = mem_ff;
    assign cpu_irq = irq_ff;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence s_fetch_last;
        st_ff == ST_FWAIT && idx_ff == LAST_BYTE;
    endsequence
    sequence s_load;
        s_fetch_last ##1 st_ff == ST_LOAD;
    endsequence

    chk_src_bytes: assert property (s_load |=> src_ff[cur_ff] == {$past(raw_ff[B_SRC_HI], 2), $past(raw_ff[B_SRC_LO], 2)})
        else $error("source pointer byte order wrong");
    chk_dst_bytes: assert property (s_load |=> dst_ff[cur_ff] == {$past(raw_ff[B_DST_HI], 2), $past(raw_ff[B_DST_LO], 2)})
        else $error("target pointer byte order wrong");
    chk_unit_width: assert property (rd_ev |=> mem_ff.rd && mem_ff.word == $past(cd.word))
        else $error("read width differs from descriptor");
    chk_desc_area: assert property (st_ff == ST_FETCH && alive && !cpu_req && cur_ff != 3'h0 |=> mem_ff.addr == $past(ptr1_ff) + 16'(($past(cur_ff) - 3'h1) * DESC_BYTES) + 16'($past(idx_ff)))
        else $error("descriptor area address wrong");
    chk_done_flag: assert property (done_ev |=> flag_ff[$past(cur_ff)])
        else $error("done flag not set on completion");
    chk_arm_clear: assert property (done_ev && !repeat_kind && !reg_wr |=> !arm_ff[$past(cur_ff)])
        else $error("arm bit kept after one-shot completion");
    chk_irq_gate: assert property (|irq_ff |-> $past(cd.ie) && irq_ff == $past(done_vec))
        else $error("interrupt raised while disabled");
    chk_low_prio: assert property (rd_ev && cd.prio == P_LOW |-> !cpu_req)
        else $error("low priority access took bus from cpu");
    chk_fetch_run: assert property (st_ff == ST_FETCH && !cpu_req && alive |=> st_ff == ST_FWAIT ##1 st_ff != ST_FWAIT)
        else $error("descriptor fetch sequence broken");
endmodule : dma_desc_engine

// file: test/mem_model.sv
`timescale 1ns/1ps
module mem_model import dma_desc_pkg::*; (
    input wire logic ref_clk,
    input wire mem_req_t mem_out,
    output logic [15:0] mem_rdata
);
    logic [7:0] mem [0:65535];
    logic [15:0] junk_ff = 16'h5A5A;
    // answers while rd stands, taken at the edge ending it; toggling junk otherwise
    assign mem_rdata = (mem_out.rd !== 1'b1) ? junk_ff
        : mem_out.word ? {mem[mem_out.addr + 16'h0001], mem[mem_out.addr]}
        : {~mem[mem_out.addr], mem[mem_out.addr]};
    always @(posedge ref_clk) begin
        junk_ff <= ~junk_ff;
        if (mem_out.wr === 1'b1) begin
            mem[mem_out.addr] <= mem_out.wdata[7:0];
            if (mem_out.word) begin
                mem[mem_out.addr + 16'h0001] <= mem_out.wdata[15:8];
            end
        end
    end
endmodule : mem_model

// file: test/testbench.sv
`timescale 1ns/1ps
module testbench import dma_desc_pkg::*; ;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    mem_req_t mem_out;
    logic [15:0] mem_rdata;
    logic cpu_req = 1'b0;
    logic [NTRIG-1:0] trigger_select_src = '0;
    logic [NCH-1:0] cpu_irq;
    int num_errors = 0;
    int checked = 0;
    int wr_cnt = 0;
    int irq_cnt = 0;
    logic [7:0] v;
    logic [2:0] vc [6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h7, 3'h2};
    logic [7:0] vb [6] = '{8'h54, 8'h54, 8'h54, 8'h54, 8'h54, 8'h50};
    logic [7:0] ve [6] = '{8'h03, 8'h02, 8'h04, 8'h04, 8'h04, 8'h04};

    always #4 ref_clk = ~ref_clk;

    dma_desc_engine u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_out(mem_out), .mem_rdata(mem_rdata),
        .cpu_req(cpu_req), .trigger_select_src(trigger_select_src), .cpu_irq(cpu_irq));
    mem_model u_mem (.ref_clk(ref_clk), .mem_out(mem_out), .mem_rdata(mem_rdata));

    always @(posedge ref_clk) begin
        if (mem_out.wr === 1'b1) wr_cnt++;
        if (|cpu_irq) irq_cnt++;
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : report_and_stop

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [2:0] a);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(posedge ref_clk);
        v = reg_rdata;
    endtask : rd

    task automatic pulse(input int k);
        @(posedge ref_clk);
        trigger_select_src <= 30'(1) << k;
        @(posedge ref_clk);
        trigger_select_src <= '0;
    endtask : pulse

    task automatic wait_flag(input int ch);
        for (int k = 0; k < 300; k++) begin
            rd(3'h2);
            if (v[ch] === 1'b1) break;
        end
        chk("done flag", {7'h00, v[ch]}, 8'h01);
        if (v[ch] !== 1'b1) report_and_stop();
        wr(3'h2, 8'(1 << ch));
    endtask : wait_flag

    task automatic wait_wr(input int n);
        for (int k = 0; k < 300 && wr_cnt < n; k++) @(posedge ref_clk);
        chk("unit writes", 8'(wr_cnt), 8'(n));
        if (wr_cnt < n) report_and_stop();
    endtask : wait_wr

    task automatic sd(input int ch, input logic [15:0] s, d, input logic [7:0] b4, b5, b6, b7);
        logic [63:0] w;
        logic [15:0] b;
        w = {s, d, b4, b5, b6, b7};
        b = (ch == 0) ? 16'h0040 : 16'h0078 + 16'(8 * ch);
        for (int k = 0; k < 8; k++) u_mem.mem[b + 16'(k)] = w[63 - 8 * k -: 8];
        wr_cnt = 0;
    endtask : sd

    task automatic go();
        wr(3'h0, 8'h01);
        wr(3'h1, 8'h01);
    endtask : go

    initial begin
        repeat (100000) @(posedge ref_clk);
        num_errors++;
        report_and_stop();
    end

    initial begin
        for (int k = 0; k < 8; k++) begin
            u_mem.mem[16'h0100 + 16'(k)] = 8'h10 + 8'(k);
            u_mem.mem[16'h0200 + 16'(k)] = 8'hEE;
        end
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        for (int a = 0; a < 8; a++) begin
            rd(3'(a));
            chk("reset value", v, 8'h00);
        end
        wr(3'h3, 8'h00);
        wr(3'h4, 8'h40);
        wr(3'h5, 8'h00);
        wr(3'h6, 8'h80);
        $display("test reset done");
        sd(0, 16'h0100, 16'h0200, 8'h00, 8'h03, 8'h20, 8'h58);
        go();
        wait_flag(0);
        for (int k = 0; k < 3; k++) chk("target", u_mem.mem[16'h0200 + 16'(k)], 8'h10 + 8'(k));
        chk("past count", u_mem.mem[16'h0203], 8'hEE);
        chk("writes", 8'(wr_cnt), 8'h03);
        chk("irq pulses", 8'(irq_cnt), 8'h01);
        rd(3'h0);
        chk("arm", v, 8'h00);
        $display("test block done");
        sd(0, 16'h0100, 16'h0305, 8'h00, 8'h02, 8'h00, 8'h70);
        go();
        wait_wr(1);
        rd(3'h2);
        chk("early flag", v, 8'h00);
        wr(3'h1, 8'h01);
        wait_flag(0);
        chk("down step", u_mem.mem[16'h0304], 8'h11);
        chk("irq pulses", 8'(irq_cnt), 8'h01);
        $display("test single done");
        for (int t = 0; t < 6; t++) begin
            u_mem.mem[16'h0100] = 8'h82;
            sd(0, 16'h0100, 16'h0200, {vc[t], 5'h00}, 8'h04, 8'h20, vb[t]);
            go();
            wait_flag(0);
            chk("variable count", 8'(wr_cnt), ve[t]);
        end
        $display("test variable done");
        u_mem.mem[16'h0100] = 8'h03;
        u_mem.mem[16'h0101] = 8'hE0;
        sd(0, 16'h0100, 16'h0200, 8'h40, 8'h08, 8'hA0, 8'h50);
        go();
        wait_flag(0);
        chk("word count", 8'(wr_cnt), 8'h03);
        chk("word high", u_mem.mem[16'h0201], 8'hE0);
        chk("word step", u_mem.mem[16'h0205], 8'h15);
        $display("test word done");
        sd(2, 16'h0100, 16'h0240, 8'h00, 8'h02, 8'h02, 8'h50);
        sd(3, 16'h0100, 16'h0280, 8'h00, 8'h01, 8'h21, 8'h50);
        wr(3'h0, 8'h0C);
        repeat (60) @(posedge ref_clk);
        pulse(1);
        repeat (20) @(posedge ref_clk);
        chk("stray trigger", 8'(wr_cnt), 8'h00);
        pulse(0);
        wait_wr(1);
        pulse(0);
        wait_flag(2);
        wait_flag(3);
        chk("chained", u_mem.mem[16'h0280], 8'h03);
        chk("triggered", u_mem.mem[16'h0241], 8'hE0);
        $display("test trigger done");
        sd(0, 16'h0100, 16'h0200, 8'h00, 8'h01, 8'h20, 8'h50);
        wr(3'h0, 8'h01);
        repeat (40) @(posedge ref_clk);
        cpu_req <= 1'b1;
        wr(3'h1, 8'h01);
        repeat (30) @(posedge ref_clk);
        chk("held off", 8'(wr_cnt), 8'h00);
        cpu_req <= 1'b0;
        wait_flag(0);
        sd(0, 16'h0100, 16'h0200, 8'h00, 8'h02, 8'h60, 8'h52);
        wr(3'h0, 8'h01);
        repeat (40) @(posedge ref_clk);
        cpu_req <= 1'b1;
        wr(3'h1, 8'h01);
        wait_flag(0);
        chk("high prio", 8'(wr_cnt), 8'h02);
        rd(3'h0);
        chk("still armed", v, 8'h01);
        wr(3'h1, 8'h01);
        wait_flag(0);
        chk("reloaded", 8'(wr_cnt), 8'h04);
        wr(3'h0, 8'h81);
        rd(3'h0);
        chk("aborted", v, 8'h00);
        cpu_req <= 1'b0;
        $display("test priority done");
        sd(0, 16'h0100, 16'h0210, 8'h00, 8'h02, 8'h40, 8'hA1);
        wr(3'h0, 8'h01);
        repeat (40) @(posedge ref_clk);
        cpu_req <= 1'b1;
        wr(3'h1, 8'h01);
        wait_wr(1);
        wr(3'h1, 8'h01);
        wait_flag(0);
        chk("guaranteed", u_mem.mem[16'h0210], 8'h03);
        chk("double step", u_mem.mem[16'h0212], 8'h12);
        rd(3'h0);
        chk("single rearmed", v, 8'h01);
        wr(3'h0, 8'h81);
        cpu_req <= 1'b0;
        $display("test guaranteed done");
        report_and_stop();
    end
endmodule : testbench
